// ===== src/tdp_dimmer.sv
// Phase-angle triac firing controller for a touch dimmer
`timescale 1ns/100ps
module tdp_dimmer (
    input wire logic clk_sys,        // 40 MHz system clock
    input wire logic rst,            // Synchronous active-high reset
    input wire logic up_request,     // Up touch level, high = pressed
    input wire logic down_request,   // Down touch level, high = pressed
    input wire logic remote_request, // Remote switch level, high = pressed
    input wire logic mains_sync,     // Mains polarity, toggles at zero crossings
    input wire logic triac_on,       // High once triac conducts
    output logic trig_n_o,           // Trigger pin drive value (always low)
    output logic trig_n_oe,          // Trigger pin enable, high while sinking
    output logic lamp_on,            // On/off state
    output logic [4:0] level         // Stored brightness level
);
    // Perceptual table: brightness level to preset of the phase counter
    function automatic logic [6:0] level_preset(input logic [4:0] lv);
        logic [6:0] p;
        p = 7'h7f;
        // Coarse steps at the dim end, fine at the bright end; level 31 reaches preset 0
        unique case (lv[4:3])
            2'h0: p = 7'h7f - 7'({lv[2:0], 2'h0}) - 7'({4'h0, lv[2:0]});
            2'h1: p = 7'h59 - 7'({lv[2:0], 2'h0});
            2'h2: p = 7'h38 - 7'({lv[2:0], 2'h0});
            2'h3: p = 7'h15 - 7'({3'h0, lv[2:0], 1'b0}) - 7'({4'h0, lv[2:0]});
        endcase
        return p;
    endfunction

    typedef enum logic [1:0] {TDP_IDLE, TDP_COUNT, TDP_FIRE, TDP_DONE} tdp_phase_t;
    typedef struct packed {
        logic on;
        logic [4:0] lvl;
        logic [6:0] cnt_a;
        logic [6:0] cnt_b;
        logic [7:0] dly;
        tdp_phase_t ph;
        logic sync_d;
        logic [5:0] ramp;
        logic both_seen;
    } tdp_st_t;
    tdp_st_t s_r, s_nxt;

    logic tick;
    logic any_press;
    logic both;
    logic half_tick;
    logic brief_cmd;
    logic long_start;
    logic long_active;
    logic up_eff;
    logic down_eff;

    tdp_tick_gen #(.DIV(tdp_pkg::TICK_CYC)) u_tick (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick)
    );

    // Remote input is a single switch: it acts as both contacts at once
    assign up_eff = up_request | remote_request;
    assign down_eff = down_request | remote_request;
    assign any_press = up_eff | down_eff;
    assign both = up_request & down_request;
    assign half_tick = (mains_sync != s_r.sync_d);

    tdp_press_class u_class (
        .clk_sys(clk_sys),
        .rst(rst),
        .active(any_press),
        .half_tick(half_tick),
        .brief_cmd(brief_cmd),
        .long_start(long_start),
        .long_active(long_active)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.sync_d = mains_sync;
        if (!any_press) begin
            s_nxt.both_seen = 1'b0;
        end else if (both) begin
            s_nxt.both_seen = 1'b1;
        end
        // Command handling
        if (brief_cmd) begin
            s_nxt.on = !s_r.on;
        end
        if (long_start && (s_r.both_seen || both)) begin
            s_nxt.on = 1'b1;
        end
        if (long_start && !both && !s_r.both_seen) begin
            s_nxt.on = 1'b1;
        end
        if (long_active && !both && !s_r.both_seen && half_tick) begin
            if (s_r.ramp == 6'(tdp_pkg::RAMP_HALVES - 1)) begin
                s_nxt.ramp = 6'h00;
                // Saturating ramp, one level per step so 32 steps span 3.52 s
                if (up_request && !down_request && s_r.lvl != tdp_pkg::LEVEL_MAX) begin
                    s_nxt.lvl = s_r.lvl + 5'h01;
                end else if (down_request && !up_request && s_r.lvl != tdp_pkg::LEVEL_MIN) begin
                    s_nxt.lvl = s_r.lvl - 5'h01;
                end
            end else begin
                s_nxt.ramp = s_r.ramp + 6'h01;
            end
        end else if (!long_active) begin
            s_nxt.ramp = 6'h00;
        end
        // Phase control: counter A preset from level, B from zero; both run on the tick
        unique case (s_r.ph)
            TDP_IDLE: begin
            end
            TDP_COUNT: begin
                if (tick) begin
                    s_nxt.cnt_a = s_r.cnt_a + 7'h01;
                    s_nxt.cnt_b = s_r.cnt_b + 7'h01;
                    s_nxt.dly = s_r.dly + 8'h01;
                    // Fire when DELAY_MIN plus the spacing between presets has been counted out, or at DELAY_MAX_TICKS
                    if (s_r.dly + 8'h01 >= {1'b0, tdp_pkg::DELAY_MIN} + {1'b0, 7'(s_r.cnt_a - s_r.cnt_b)}
                        || s_r.dly + 8'h01 >= tdp_pkg::DELAY_MAX_TICKS) begin
                        s_nxt.ph = TDP_FIRE;
                    end
                end
            end
            TDP_FIRE: begin
                if (tick || triac_on) begin
                    s_nxt.ph = TDP_DONE;
                end
            end
            TDP_DONE: begin
            end
        endcase
        if (half_tick) begin
            s_nxt.cnt_a = level_preset(s_r.lvl);
            // Reference counter starts at zero, so the spacing equals the level preset
            s_nxt.cnt_b = 7'h00;
            s_nxt.dly = 8'h00;
            s_nxt.ph = (s_r.on || s_nxt.on) ? TDP_COUNT : TDP_IDLE;
        end
        if (!s_nxt.on && s_nxt.ph != TDP_IDLE) begin
            s_nxt.ph = TDP_IDLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign trig_n_o = 1'b0;
    assign trig_n_oe = (s_r.ph == TDP_FIRE) && !triac_on;
    assign lamp_on = s_r.on;
    assign level = s_r.lvl;
endmodule // tdp_dimmer

// ===== src/tdp_pkg.sv
// Package with constants for the touch dimmer phase controller
package tdp_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int TICK_NS = 50000;
    localparam int TICK_CYC = (TICK_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int CNT_W = 7;
    localparam logic [6:0] DELAY_MIN = 7'h20;
    localparam logic [6:0] DELAY_MAX = 7'h7f;
    localparam logic [7:0] DELAY_MAX_TICKS = 8'ha0;
    localparam int LEVEL_W = 5;
    localparam logic [4:0] LEVEL_MIN = 5'h00;
    localparam logic [4:0] LEVEL_MAX = 5'h1f;
    localparam int HALF_MS = 10;
    localparam int BRIEF_MS = 80;
    localparam int LONG_MS = 320;
    localparam int BRIEF_HALVES = BRIEF_MS / HALF_MS;
    localparam int LONG_HALVES = LONG_MS / HALF_MS;
    localparam int RAMP_MS = 3800;
    localparam int RAMP_HALVES = (RAMP_MS / HALF_MS) / 32;
    localparam int DUR_W = 6;
    typedef enum logic [1:0] {TDP_CMD_NONE, TDP_CMD_BRIEF, TDP_CMD_LONG} tdp_cmd_t;
endpackage

// ===== src/tdp_press_class.sv
// Press duration classifier counting mains half cycles
`timescale 1ns/100ps
module tdp_press_class (
    input wire logic clk_sys,     // System clock
    input wire logic rst,         // Synchronous reset
    input wire logic active,      // Combined press level
    input wire logic half_tick,   // One pulse per mains half cycle
    output logic brief_cmd,       // Pulse on release of a brief press
    output logic long_start,      // Pulse when a press becomes long
    output logic long_active      // Level while a long press lasts
);
    typedef struct packed {
        logic [5:0] dur;
        logic is_long;
    } tdp_pc_st_t;
    tdp_pc_st_t s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        brief_cmd = 1'b0;
        long_start = 1'b0;
        if (!active) begin
            // Under 80 ms is ignored; released 80..320 ms is brief
            if (!s_r.is_long && s_r.dur >= 6'(tdp_pkg::BRIEF_HALVES)) begin
                brief_cmd = 1'b1;
            end
            s_nxt.dur = 6'h00;
            s_nxt.is_long = 1'b0;
        end else if (half_tick && !s_r.is_long) begin
            s_nxt.dur = s_r.dur + 6'h01;
            if (s_nxt.dur >= 6'(tdp_pkg::LONG_HALVES)) begin
                s_nxt.is_long = 1'b1;
                long_start = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign long_active = s_r.is_long;
endmodule // tdp_press_class

// ===== src/tdp_tick_gen.sv
// Internal timing tick generator, one pulse per 50 us
`timescale 1ns/100ps
module tdp_tick_gen #(
    parameter int DIV = tdp_pkg::TICK_CYC
) (
    input wire logic clk_sys, // System clock
    input wire logic rst,     // Synchronous reset
    output logic tick         // One-cycle tick pulse
);
    typedef struct packed {
        logic [15:0] cnt;
    } tdp_tick_st_t;
    tdp_tick_st_t s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (s_r.cnt == 16'(DIV - 1)) begin
            s_nxt.cnt = 16'h0000;
        end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = (s_r.cnt == 16'(DIV - 1));
endmodule // tdp_tick_gen

// ===== verification/tdp_dimmer_asserts.sv
// Port checker for the dimmer
`timescale 1ns/100ps
module tdp_dimmer_chk (
    input wire logic clk_sys, // Clock
    input wire logic rst, // Reset
    input wire logic up_request, // Up
    input wire logic down_request, // Down
    input wire logic remote_request, // Remote
    input wire logic mains_sync, // Mains
    input wire logic triac_on, // Triac
    input wire logic trig_n_o, // Pin value
    input wire logic trig_n_oe, // Pin enable
    input wire logic lamp_on, // On state
    input wire logic [4:0] level // Level
);
    localparam int TK = tdp_pkg::TICK_CYC;
    int since_r;
    int width_r;
    logic sync_r;
    logic fired_r;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    always_ff @(posedge clk_sys) begin
        sync_r <= mains_sync;
        if (rst) begin
            since_r <= 0;
            width_r <= 0;
            fired_r <= 1'b0;
        end else begin
            since_r <= (mains_sync != sync_r) ? 0 : since_r + 1;
            width_r <= trig_n_oe ? width_r + 1 : 0;
            fired_r <= (mains_sync != sync_r) ? 1'b0 : (fired_r | trig_n_oe);
        end
    end
    reset_clear_a: assert property (disable iff (1'b0) rst |=> !lamp_on && level == 5'h00 && !trig_n_oe)
        else $error("state not cleared by reset");
    sink_low_a: assert property (trig_n_oe |-> !trig_n_o)
        else $error("pin driven high");
    conduct_stop_a: assert property (triac_on |-> !trig_n_oe)
        else $error("pulse while triac conducts");
    fire_on_a: assert property ($rose(trig_n_oe) |-> lamp_on)
        else $error("pulse while off");
    fire_window_a: assert property ($rose(trig_n_oe) |-> since_r >= 31 * TK && since_r <= 161 * TK)
        else $error("firing delay out of range");
    pulse_width_a: assert property (width_r <= TK + 1)
        else $error("pulse too long");
    one_shot_a: assert property ($rose(trig_n_oe) |-> !fired_r)
        else $error("second pulse in half cycle");
    level_step_a: assert property (level != $past(level) |->
        level == $past(level) + 5'h01 || level == $past(level) - 5'h01)
        else $error("level jumped");
    off_hold_a: assert property (!lamp_on && !$past(lamp_on) |-> level == $past(level))
        else $error("level moved while off");
    off_quiet_a: assert property ($fell(lamp_on) |-> !up_request && !down_request && !remote_request)
        else $error("switched off during press");
    cover property ($rose(lamp_on));
    cover property ($rose(trig_n_oe));
    cover property (level == 5'h1f);
endmodule // tdp_dimmer_chk
bind tdp_dimmer tdp_dimmer_chk u_chk (.clk_sys(clk_sys), .rst(rst), .up_request(up_request),
    .down_request(down_request), .remote_request(remote_request), .mains_sync(mains_sync),
    .triac_on(triac_on), .trig_n_o(trig_n_o), .trig_n_oe(trig_n_oe), .lamp_on(lamp_on), .level(level));

// ===== verification/tdp_dimmer_bench.sv
// Self-checking bench for the dimmer
`timescale 1ns/100ps
`define CHECK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin fails++; \
    $display("unexpected at %0t: %s", $time, msg); end end
module tdp_dimmer_bench;
    localparam int TK = tdp_pkg::TICK_CYC;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [2:0] req = 3'h0;
    logic mains_sync = 1'b0;
    logic triac_on;
    logic trig_n_o;
    logic trig_n_oe;
    logic lamp_on;
    logic [4:0] level;
    int fails = 0;
    int total_checks = 0;
    int m_lamp = 0;
    int m_lvl = 0;
    int n;
    always #12.5 clk_sys = ~clk_sys;
    tdp_dimmer DUT (.clk_sys(clk_sys), .rst(rst), .up_request(req[0]), .down_request(req[1]),
        .remote_request(req[2]), .mains_sync(mains_sync), .triac_on(triac_on), .trig_n_o(trig_n_o),
        .trig_n_oe(trig_n_oe), .lamp_on(lamp_on), .level(level));
    tdp_triac_model u_triac (.clk_sys(clk_sys), .mains_sync(mains_sync), .trig_n_o(trig_n_o),
        .trig_n_oe(trig_n_oe), .triac_on(triac_on));
    task automatic final_report;
        if (fails == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Short half cycles keep press timing cheap; only edges are counted
    task automatic press(input logic [2:0] who, input int k);
        @(negedge clk_sys);
        req = who;
        repeat (k) begin
            repeat (6) @(negedge clk_sys);
            mains_sync = ~mains_sync;
        end
        repeat (3) @(negedge clk_sys);
        req = 3'h0;
        repeat (4) @(negedge clk_sys);
        if (k >= 32) begin
            m_lamp = 1;
            if (who == 3'h1) m_lvl = 31;
            if (who == 3'h2) m_lvl = 0;
        end else if (k >= 8) begin
            m_lamp = 1 - m_lamp;
        end
        `CHECK(lamp_on, 1'(m_lamp), "on state")
        `CHECK(level, 5'(m_lvl), "brightness")
    endtask
    initial begin
        n = $urandom(87);
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        `CHECK(lamp_on, 1'b0, "reset state")
        `CHECK(level, 5'h00, "reset level")
        press(3'h1, 7);
        press(3'h2, 8);
        press(3'h4, 31);
        for (int i = 0; i < 6; i++) begin
            press(3'h1 << ($urandom % 3), 1 + $urandom % 7);
            press(3'h1 << ($urandom % 3), 8 + $urandom % 24);
        end
        if (m_lamp == 1) press(3'h1, 8);
        press(3'h1, 400);
        press(3'h2, 8);
        press(3'h3, 40);
        press(3'h3, 40);
        press(3'h4, 40);
        press(3'h2, 400);
        press(3'h1, 400);
        mains_sync = ~mains_sync;
        n = 0;
        while (!trig_n_oe && n < 40 * TK) begin
            @(negedge clk_sys);
            n++;
        end
        `CHECK(n >= 31 * TK && n <= 34 * TK, 1'b1, "firing delay")
        n = 0;
        while (trig_n_oe && n < 2 * TK) begin
            @(negedge clk_sys);
            n++;
        end
        `CHECK(triac_on, 1'b1, "triac not fired")
        `CHECK(n <= 6, 1'b1, "pulse not cut")
        `CHECK(trig_n_o, 1'b0, "pin value")
        final_report;
    end
    initial begin
        #(25 * 90000);
        fails++;
        final_report;
    end
endmodule // tdp_dimmer_bench

// ===== verification/tdp_triac_model.sv
// Triac gate load on the trigger pin
`timescale 1ns/100ps
module tdp_triac_model #(
    parameter int LAG = 3
) (
    input wire logic clk_sys, // Clock
    input wire logic mains_sync, // Mains polarity
    input wire logic trig_n_o, // Pin value
    input wire logic trig_n_oe, // Pin enable
    output logic triac_on // Conducting
);
    logic gate_n;
    logic sync_r = 1'b0;
    int low_r = 0;
    // Gate resistor pulls the released pin high
    assign gate_n = trig_n_oe ? trig_n_o : 1'b1;
    initial triac_on = 1'b0;
    always @(posedge clk_sys) begin
        sync_r <= mains_sync;
        low_r <= gate_n ? 0 : low_r + 1;
        // Current dies at the zero crossing, so conduction ends there
        if (mains_sync != sync_r) begin
            triac_on <= 1'b0;
        end else if (low_r >= LAG) begin
            triac_on <= 1'b1;
        end
    end
endmodule // tdp_triac_model
